// [core/lcs_charge_sequencer.v]
// charge-cycle sequencer for a single-cell lithium charger, with apb registers
// Overview of operation
// - cycle runs precondition, constant current, constant voltage, end of charge
// - no charging unless adapter above lockout and battery temperature in window
// - battery present and below precondition threshold starts preconditioning
// - preconditioning current command is programmed current divided by ten
// - above precondition threshold moves to fast charge at programmed current
// - reaching 4.2 v regulation in fast charge moves to constant voltage
// - current down to 7.5 percent in constant voltage ends charge, sleep
// - after end of charge sleep until battery drops below recharge threshold
// - adapter lost or below battery or lockout gives sleep, auto resume
// - die above loop entry cuts fast current at once to 0.44 of programmed
// - thermal loop rechecks every 330 ms, steps current up or holds it
// - die below loop exit leaves thermal loop, full current restored
// - adapter present pin pulled low while adapter voltage is seen
// - lockout suspends charge; recovery reassesses battery and picks stage
// - enable active high; low forces sleep regardless of stage
// - re-enable resets controller and restarts from measured battery voltage
// - battery over-voltage or die over-temperature shuts charging down
// - battery over-temperature during charge shuts charging down
// - every fault shown on both status leds and in twelve-state status code
// - safety timer: 25 min precondition, 3 h precondition plus fast, 3 h again in cv
// - recharge threshold sits 0.1 v below regulation voltage
// - after over-voltage, charging resumes once battery falls below threshold
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"

module lcs_charge_sequencer #(
  parameter integer TICK_CYCLES = `LCS_TICK_CYCLES,
  parameter integer PRE_TIMEOUT_TICKS = `LCS_PRE_TIMEOUT_TICKS,
  parameter integer CHG_TIMEOUT_TICKS = `LCS_CHG_TIMEOUT_TICKS,
  parameter integer LOOP_TICKS = `LCS_LOOP_TICKS
) (
  // clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // comparator results and enable pin
  input  wire        charge_enable_in,
  input  wire        adapter_above_uvlo,
  input  wire        adapter_above_battery,
  input  wire        battery_temp_in_window,
  input  wire        battery_present,
  input  wire        battery_above_precond,
  input  wire        battery_at_regulation,
  input  wire        battery_below_recharge,
  input  wire        battery_over_voltage,
  input  wire        current_below_term,
  input  wire        die_above_loop_in,
  input  wire        die_below_loop_out,
  input  wire        die_over_temp,
  // charge current command in ma and status
  output reg  [11:0] charge_current_cmd,
  output reg  [3:0]  charge_status_code,
  // open-drain pins, enable low while pulling low
  output wire        adapter_present_n_o,
  output wire        adapter_present_n_oe_n,
  output wire        status_led_a_o,
  output wire        status_led_a_oe_n,
  output wire        status_led_b_o,
  output wire        status_led_b_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  wire [`LCS_NSYNC-1:0] raw_in;
  reg  [`LCS_NSYNC-1:0] sync1_reg;
  reg  [`LCS_NSYNC-1:0] sync2_reg;

  assign raw_in = {die_over_temp, die_below_loop_out, die_above_loop_in,
                   current_below_term, battery_over_voltage,
                   battery_below_recharge, battery_at_regulation,
                   battery_above_precond, battery_present,
                   battery_temp_in_window, adapter_above_battery,
                   adapter_above_uvlo, charge_enable_in};

  // first stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < `LCS_NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire en_pin    = sync2_reg[`LCS_I_EN];
  wire uvlo_ok   = sync2_reg[`LCS_I_UVLO];
  wire adp_ok    = sync2_reg[`LCS_I_ABOVE_BAT];
  wire temp_ok   = sync2_reg[`LCS_I_TEMP_OK];
  wire bat_here  = sync2_reg[`LCS_I_PRESENT];
  wire above_pre = sync2_reg[`LCS_I_ABOVE_PRE];
  wire at_reg    = sync2_reg[`LCS_I_AT_REG];
  wire below_rch = sync2_reg[`LCS_I_BELOW_RCH];
  wire ovp       = sync2_reg[`LCS_I_OVP];
  wire term      = sync2_reg[`LCS_I_TERM];
  wire loop_in   = sync2_reg[`LCS_I_LOOP_IN];
  wire loop_out  = sync2_reg[`LCS_I_LOOP_OUT];
  wire die_ot    = sync2_reg[`LCS_I_DIE_OT];

  ////////////////////////////////////////////////////////////////////////////
  // apb registers

  reg        ctrl_en_reg;
  reg [11:0] prog_current_reg;

  wire acc      = psel & penable;
  wire map_hit  = (paddr == `LCS_ADDR_CTRL) | (paddr == `LCS_ADDR_PROG) |
                  (paddr == `LCS_ADDR_STAT) | (paddr == `LCS_ADDR_CMD);

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~map_hit;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_en_reg      <= `LCS_CTRL_RST;
      prog_current_reg <= `LCS_PROG_RST;
    end else if (acc & pwrite) begin
      if (paddr == `LCS_ADDR_CTRL)
        ctrl_en_reg <= pwdata[0];
      if (paddr == `LCS_ADDR_PROG)
        prog_current_reg <= pwdata[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 50 us system tick

  reg [15:0] tick_cnt_reg;
  wire       tick = (tick_cnt_reg == TICK_CYCLES[15:0] - 16'h0001);

  // stage steps below wait for this strobe; disable, supply loss, hazards and thermal entry act at once
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      tick_cnt_reg <= 16'h0000;
    else if (tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage machine

  localparam [2:0] ST_SLEEP = `LCS_ST_SLEEP;
  localparam [2:0] ST_PRE   = `LCS_ST_PRE;
  localparam [2:0] ST_FAST  = `LCS_ST_FAST;
  localparam [2:0] ST_CV    = `LCS_ST_CV;
  localparam [2:0] ST_FAULT = `LCS_ST_FAULT;

  reg [2:0]  state_reg, state_next;
  reg        done_reg, done_next;
  reg        tmo_reg, tmo_next;
  reg [27:0] sfty_cnt_reg, sfty_cnt_next;
  reg        loop_act_reg, loop_act_next;
  reg [6:0]  loop_pct_reg, loop_pct_next;
  reg [12:0] loop_cnt_reg, loop_cnt_next;

  wire enabled  = en_pin & ctrl_en_reg;
  wire supply   = uvlo_ok & adp_ok;
  wire start_ok = supply & temp_ok & bat_here;
  wire hazard   = ovp | die_ot | ~temp_ok;
  wire charging = (state_reg == ST_PRE) | (state_reg == ST_FAST) | (state_reg == ST_CV);

  // stage entered from sleep, chosen from the measured battery voltage
  function [2:0] pick_stage;
    input pre_ok;
    input reg_ok;
    begin
      if (!pre_ok)
        pick_stage = ST_PRE;
      else if (reg_ok)
        pick_stage = ST_CV;
      else
        pick_stage = ST_FAST;
    end
  endfunction

  always @* begin
    state_next    = state_reg;
    done_next     = done_reg;
    tmo_next      = tmo_reg;
    sfty_cnt_next = sfty_cnt_reg;
    loop_act_next = loop_act_reg;
    loop_pct_next = loop_pct_reg;
    loop_cnt_next = loop_cnt_reg;
    if (!enabled) begin
      // disable forces sleep and clears all history except the loop counter
      state_next    = ST_SLEEP;
      done_next     = 1'b0;
      tmo_next      = 1'b0;
      sfty_cnt_next = 28'h0000000;
      loop_act_next = 1'b0;
      loop_pct_next = `LCS_FULL_PCT;
    end else if (!supply) begin
      // timer fault also clears on adapter loss: a fresh supply is a fresh cycle
      state_next    = ST_SLEEP;
      tmo_next      = 1'b0;
      loop_act_next = 1'b0;
      loop_pct_next = `LCS_FULL_PCT;
    end else if (charging & hazard) begin
      state_next    = ST_FAULT;
      loop_act_next = 1'b0;
      loop_pct_next = `LCS_FULL_PCT;
    end else if (tick) begin
      case (state_reg)
        ST_SLEEP: begin
          if (done_reg & below_rch)
            done_next = 1'b0;
          if (start_ok & ~done_reg & ~tmo_reg & ~ovp & ~die_ot) begin
            state_next    = pick_stage(above_pre, at_reg);
            sfty_cnt_next = 28'h0000000;
          end
        end
        ST_PRE: begin
          sfty_cnt_next = sfty_cnt_reg + 28'h0000001;
          if (above_pre)
            state_next = ST_FAST;
          else if (sfty_cnt_reg >= PRE_TIMEOUT_TICKS[27:0] - 28'h0000001) begin
            state_next = ST_FAULT;
            tmo_next   = 1'b1;
          end
        end
        ST_FAST: begin
          sfty_cnt_next = sfty_cnt_reg + 28'h0000001;
          if (at_reg) begin
            state_next    = ST_CV;
            sfty_cnt_next = 28'h0000000;
            loop_act_next = 1'b0;
            loop_pct_next = `LCS_FULL_PCT;
          end else if (sfty_cnt_reg >= CHG_TIMEOUT_TICKS[27:0] - 28'h0000001) begin
            state_next = ST_FAULT;
            tmo_next   = 1'b1;
          end else if (loop_act_reg & loop_out) begin
            loop_act_next = 1'b0;
            loop_pct_next = `LCS_FULL_PCT;
          end else if (loop_act_reg) begin
            if (loop_cnt_reg == LOOP_TICKS[12:0] - 13'h0001) begin
              loop_cnt_next = 13'h0000;
              // still hot: hold the level reached
              if (!loop_in && loop_pct_reg < `LCS_FULL_PCT)
                loop_pct_next = loop_pct_reg + `LCS_LOOP_STEP_PCT;
            end else
              loop_cnt_next = loop_cnt_reg + 13'h0001;
          end
        end
        ST_CV: begin
          sfty_cnt_next = sfty_cnt_reg + 28'h0000001;
          if (term) begin
            state_next = ST_SLEEP;
            done_next  = 1'b1;
          end else if (sfty_cnt_reg >= CHG_TIMEOUT_TICKS[27:0] - 28'h0000001) begin
            state_next = ST_FAULT;
            tmo_next   = 1'b1;
          end
        end
        ST_FAULT: begin
          // cleared conditions go back through sleep to reassess
          if (~tmo_reg & ~hazard)
            state_next = ST_SLEEP;
        end
        default: state_next = ST_SLEEP;
      endcase
    end
    // die entry cuts current at once, not on the tick; only while fast charge continues,
    // so a same-cycle move to cv, fault or sleep never leaves a stale loop state behind
    if ((state_reg == ST_FAST) & (state_next == ST_FAST) & loop_in & ~loop_act_reg) begin
      loop_act_next = 1'b1;
      loop_pct_next = `LCS_LOOP_START_PCT;
      loop_cnt_next = 13'h0000;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_SLEEP;
      done_reg     <= 1'b0;
      tmo_reg      <= 1'b0;
      sfty_cnt_reg <= 28'h0000000;
      loop_act_reg <= 1'b0;
      loop_pct_reg <= `LCS_FULL_PCT;
      loop_cnt_reg <= 13'h0000;
    end else begin
      state_reg    <= state_next;
      done_reg     <= done_next;
      tmo_reg      <= tmo_next;
      sfty_cnt_reg <= sfty_cnt_next;
      loop_act_reg <= loop_act_next;
      loop_pct_reg <= loop_pct_next;
      loop_cnt_reg <= loop_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current command and status

  wire [18:0] scaled  = prog_current_reg * loop_pct_reg;
  wire [18:0] loop_ma = scaled / 19'd100;
  reg  [11:0] cmd_next;
  reg  [3:0]  code_next;

  always @* begin
    case (state_reg)
      ST_PRE:  cmd_next = prog_current_reg / `LCS_PRE_DIV;
      ST_FAST: cmd_next = loop_act_reg ? loop_ma[11:0] : prog_current_reg;
      ST_CV:   cmd_next = prog_current_reg;
      default: cmd_next = 12'h000;
    endcase
  end

  // twelve distinct states for software
  always @* begin
    case (state_reg)
      ST_PRE:   code_next = 4'h3;
      ST_FAST:  code_next = loop_act_reg ? 4'h5 : 4'h4;
      ST_CV:    code_next = 4'h6;
      ST_FAULT: code_next = tmo_reg ? 4'hb : ovp ? 4'h8 : die_ot ? 4'h9 : 4'ha;
      default:  code_next = !supply ? 4'h0 : !enabled ? 4'h1 : done_reg ? 4'h7 : 4'h2;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      charge_current_cmd <= 12'h000;
      charge_status_code <= 4'h0;
    end else begin
      charge_current_cmd <= cmd_next;
      charge_status_code <= code_next;
    end
  end

  // leds: a on while charging, b at end of charge, both on fault
  assign status_led_a_o    = 1'b0;
  assign status_led_b_o    = 1'b0;
  assign status_led_a_oe_n = ~(charging | (state_reg == ST_FAULT));
  assign status_led_b_oe_n = ~((state_reg == ST_FAULT) | (charge_status_code == 4'h7));

  // presence pin follows the synchronised lockout comparator
  assign adapter_present_n_o    = 1'b0;
  assign adapter_present_n_oe_n = ~uvlo_ok;

  ////////////////////////////////////////////////////////////////////////////
  // apb read data, loaded in the setup cycle

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `LCS_ADDR_CTRL: prdata <= {31'h00000000, ctrl_en_reg};
        `LCS_ADDR_PROG: prdata <= {20'h00000, prog_current_reg};
        `LCS_ADDR_STAT: prdata <= {15'h0000, loop_pct_reg, tmo_reg, done_reg,
                                   loop_act_reg, state_reg, charge_status_code};
        `LCS_ADDR_CMD:  prdata <= {20'h00000, charge_current_cmd};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // lcs_charge_sequencer
`default_nettype wire

// [core/lcs_consts.vh]
// constants for the lithium charge sequencer
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH
// clock and time base
`define LCS_CLK_PERIOD_NS 4
`define LCS_TICK_PERIOD_NS 50000
`define LCS_TICK_CYCLES (`LCS_TICK_PERIOD_NS / `LCS_CLK_PERIOD_NS)
`define LCS_TICKS_PER_MS (1000000 / `LCS_TICK_PERIOD_NS)
// safety timer and thermal loop times
`define LCS_PRE_TIMEOUT_MIN 25
`define LCS_CHG_TIMEOUT_HR 3
`define LCS_PRE_TIMEOUT_TICKS (`LCS_PRE_TIMEOUT_MIN * 60 * 1000 * `LCS_TICKS_PER_MS)
`define LCS_CHG_TIMEOUT_TICKS (`LCS_CHG_TIMEOUT_HR * 3600 * 1000 * `LCS_TICKS_PER_MS)
`define LCS_LOOP_MS 330
`define LCS_LOOP_TICKS (`LCS_LOOP_MS * `LCS_TICKS_PER_MS)
// current fractions: precondition divider, loop levels in percent of the programmed value
`define LCS_PRE_DIV 12'd10
`define LCS_LOOP_START_PCT 7'd44
`define LCS_LOOP_STEP_PCT 7'd4
`define LCS_FULL_PCT 7'd100
// register byte addresses
`define LCS_ADDR_CTRL 12'h000
`define LCS_ADDR_PROG 12'h004
`define LCS_ADDR_STAT 12'h008
`define LCS_ADDR_CMD 12'h00c
// reset values
`define LCS_CTRL_RST 1'b1
`define LCS_PROG_RST 12'h3e8
// stage codes
`define LCS_ST_SLEEP 3'd0
`define LCS_ST_PRE 3'd1
`define LCS_ST_FAST 3'd2
`define LCS_ST_CV 3'd3
`define LCS_ST_FAULT 3'd4
// synchronised comparator inputs, bit positions
`define LCS_NSYNC 13
`define LCS_I_EN 0
`define LCS_I_UVLO 1
`define LCS_I_ABOVE_BAT 2
`define LCS_I_TEMP_OK 3
`define LCS_I_PRESENT 4
`define LCS_I_ABOVE_PRE 5
`define LCS_I_AT_REG 6
`define LCS_I_BELOW_RCH 7
`define LCS_I_OVP 8
`define LCS_I_TERM 9
`define LCS_I_LOOP_IN 10
`define LCS_I_LOOP_OUT 11
`define LCS_I_DIE_OT 12
`endif

// [verification/lcs_seq_checker_assertions.sv]
// port checker for the charge sequencer, bound into the design
`timescale 1ns/1ps
`default_nettype none
module lcs_seq_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // comparators and enable
  input wire logic        charge_enable_in,
  input wire logic        adapter_above_uvlo,
  input wire logic        battery_temp_in_window,
  input wire logic        battery_over_voltage,
  input wire logic        die_over_temp,
  // outputs
  input wire logic [11:0] charge_current_cmd,
  input wire logic [3:0]  charge_status_code,
  input wire logic        adapter_present_n_o,
  input wire logic        adapter_present_n_oe_n,
  input wire logic        status_led_a_o,
  input wire logic        status_led_b_o,
  input wire logic        status_led_a_oe_n,
  input wire logic        status_led_b_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // long enough for synchroniser, stage step and command register
  sequence held_s(b);
    b [*8];
  endsequence
  // two synchroniser flops, then the pin decode
  sequence sync_s(b);
    b [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // register bus
  apb_err_a: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("pslverr does not match the address map");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  // read data is captured at the setup edge, so it shows the command one edge back
  cmd_read_a: assert property (psel && penable && !pwrite && paddr == 12'h00c |->
    prdata == {20'h0, $past(charge_current_cmd)}) else $error("command readback wrong");
  // pins and safety shutdowns
  adp_on_a: assert property (sync_s(adapter_above_uvlo) |-> !adapter_present_n_oe_n)
    else $error("adapter flag not pulled low");
  adp_off_a: assert property (sync_s(!adapter_above_uvlo) |-> adapter_present_n_oe_n)
    else $error("adapter flag not released");
  pins_low_a: assert property (!(adapter_present_n_o | status_led_a_o | status_led_b_o))
    else $error("open-drain data not low");
  en_off_a: assert property (held_s(!charge_enable_in) |-> charge_current_cmd == 12'h000)
    else $error("current commanded while disabled");
  uvlo_off_a: assert property (held_s(!adapter_above_uvlo) |->
    charge_current_cmd == 12'h000 && charge_status_code == 4'h0) else $error("charging without adapter");
  fault_off_a: assert property (held_s(battery_over_voltage || die_over_temp) |->
    charge_current_cmd == 12'h000) else $error("current commanded during fault");
  hot_off_a: assert property (held_s(!battery_temp_in_window) |-> charge_current_cmd == 12'h000)
    else $error("current commanded with battery out of window");
  code_range_a: assert property (charge_status_code <= 4'd11)
    else $error("status code beyond twelve states");
  // the code register lags the leds by one edge, so compare against the leds one edge back
  fault_leds_a: assert property (charge_status_code >= 4'd8 |->
    $past(status_led_a_oe_n) == 1'b0 && $past(status_led_b_oe_n) == 1'b0)
    else $error("fault not shown on both leds");
  chg_led_a: assert property (charge_status_code inside {[4'd3:4'd6]} |->
    $past(status_led_a_oe_n) == 1'b0 && $past(status_led_b_oe_n) == 1'b1)
    else $error("charging not shown on led a alone");
endmodule // lcs_seq_checker
bind lcs_charge_sequencer lcs_seq_checker u_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .charge_enable_in(charge_enable_in), .adapter_above_uvlo(adapter_above_uvlo),
  .battery_temp_in_window(battery_temp_in_window), .battery_over_voltage(battery_over_voltage),
  .die_over_temp(die_over_temp), .charge_current_cmd(charge_current_cmd),
  .charge_status_code(charge_status_code), .adapter_present_n_o(adapter_present_n_o),
  .adapter_present_n_oe_n(adapter_present_n_oe_n), .status_led_a_o(status_led_a_o),
  .status_led_b_o(status_led_b_o), .status_led_a_oe_n(status_led_a_oe_n),
  .status_led_b_oe_n(status_led_b_oe_n));
`default_nettype wire

// [verification/lcs_cell_model.sv]
// comparator model of the cell, adapter and thermistor around the sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_cell_model #(
  parameter logic [12:0] PRESENT_MV = 13'd1000,
  parameter logic [12:0] PRECOND_MV = 13'd3000,
  parameter logic [12:0] UVLO_MV    = 13'd3000
) (
  // analogue quantities set by the bench
  input  wire logic [12:0] bat_mv,
  input  wire logic [12:0] adp_mv,
  input  wire logic [7:0]  ts_pct,
  input  wire logic [7:0]  die_c,
  input  wire logic [11:0] cell_ma,
  input  wire logic [11:0] prog_ma,
  // comparator results in sequencer input order
  output wire logic [11:0] cmp
);
  ////////////////////////////////////////////////////////////////////////
  // supply and thermistor window, divider tied to the adapter rail
  assign cmp[0] = adp_mv > UVLO_MV;
  assign cmp[1] = adp_mv > bat_mv;
  assign cmp[2] = ts_pct > 8'd30 && ts_pct < 8'd60;
  // cell voltage thresholds
  assign cmp[3] = bat_mv > PRESENT_MV;
  assign cmp[4] = bat_mv > PRECOND_MV;
  assign cmp[5] = bat_mv >= 13'd4200;
  assign cmp[6] = bat_mv < 13'd4100;
  assign cmp[7] = bat_mv >= 13'd4400;
  // 7.5 percent is 3/40, kept in integers so no rounding creeps in
  assign cmp[8] = {6'h0, cell_ma} * 18'd40 <= {6'h0, prog_ma} * 18'd3;
  // die temperature thresholds
  assign cmp[9] = die_c > 8'd110;
  assign cmp[10] = die_c < 8'd85;
  assign cmp[11] = die_c > 8'd145;
endmodule // lcs_cell_model
`default_nettype wire

// [verification/lcs_charge_sequencer_tb.sv]
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module lcs_charge_sequencer_tb;
  logic              clock, sys_rst, psel, penable, pwrite, en, err;
  logic [11:0]       paddr, cell_ma;
  logic [31:0]       pwdata, rd;
  logic [12:0]       bat_mv, adp_mv;
  logic [7:0]        ts_pct, die_c;
  wire logic         pready, pslverr, adp_oe_n;
  wire logic [31:0]  prdata;
  wire logic [11:0]  cmd, cmp;
  wire logic [3:0]   code;
  logic [12:0]       f_bat [3] = '{13'd4500, 13'd3600, 13'd3600};
  logic [7:0]        f_die [3] = '{8'd25, 8'd150, 8'd25};
  logic [7:0]        f_ts  [3] = '{8'd45, 8'd45, 8'd20};
  logic [3:0]        f_code [3] = '{4'd8, 4'd9, 4'd10};
  int                mismatches, cmp_count, i;
  ////////////////////////////////////////////////////////////////////////
  // short counts keep the run small; expectations follow from these values
  lcs_charge_sequencer #(.TICK_CYCLES(4), .PRE_TIMEOUT_TICKS(20), .CHG_TIMEOUT_TICKS(50), .LOOP_TICKS(5)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .charge_enable_in(en), .adapter_above_uvlo(cmp[0]), .adapter_above_battery(cmp[1]),
    .battery_temp_in_window(cmp[2]), .battery_present(cmp[3]), .battery_above_precond(cmp[4]),
    .battery_at_regulation(cmp[5]), .battery_below_recharge(cmp[6]), .battery_over_voltage(cmp[7]),
    .current_below_term(cmp[8]), .die_above_loop_in(cmp[9]), .die_below_loop_out(cmp[10]),
    .die_over_temp(cmp[11]), .charge_current_cmd(cmd), .charge_status_code(code),
    .adapter_present_n_o(), .adapter_present_n_oe_n(adp_oe_n), .status_led_a_o(),
    .status_led_a_oe_n(), .status_led_b_o(), .status_led_b_oe_n());
  lcs_cell_model u_cell (.bat_mv(bat_mv), .adp_mv(adp_mv), .ts_pct(ts_pct), .die_c(die_c),
    .cell_ma(cell_ma), .prog_ma(12'h3e8), .cmp(cmp));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer; the leading idle edge keeps back-to-back calls from driving twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the command output to settle on a value
  task automatic wait_cmd(input logic [11:0] e);
    int n;
    n = 0;
    while (cmd !== e && n < 400) begin
      @(posedge clock);
      n++;
    end
    `CHK(cmd, e)
    if (cmd !== e) end_sim();
  endtask
  // poll the status word until the code arrives, bounded
  task automatic chk_code(input logic [3:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0);
      n++;
    end while (rd[3:0] !== e && n < 50);
    `CHK(rd[3:0], e)
    if (rd[3:0] !== e) end_sim();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // 250 mhz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // main sequence
  initial begin
    {sys_rst, en} = 2'b11;
    {psel, penable, pwrite, err} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rd = 32'h0;
    {bat_mv, adp_mv, ts_pct, die_c, cell_ma} = {13'd2500, 13'd0, 8'd45, 8'd25, 12'd1000};
    mismatches = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h0000_03e8)
    apb(1'b1, 12'h010, 32'h0000_0005);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    chk_code(4'd0);
    `CHK(adp_oe_n, 1'b1)
    $display("test registers done");
    adp_mv <= 13'd5000;
    wait_cmd(12'd100);
    `CHK(adp_oe_n, 1'b0)
    chk_code(4'd3);
    bat_mv <= 13'd3600;
    wait_cmd(12'd1000);
    chk_code(4'd4);
    $display("test precondition done");
    die_c <= 8'd120;
    wait_cmd(12'd440);
    die_c <= 8'd100;
    wait_cmd(12'd480);
    chk_code(4'd5);
    die_c <= 8'd70;
    wait_cmd(12'd1000);
    $display("test thermal loop done");
    bat_mv <= 13'd4200;
    chk_code(4'd6);
    cell_ma <= 12'd70;
    wait_cmd(12'd0);
    chk_code(4'd7);
    bat_mv <= 13'd4150;
    repeat (40) @(posedge clock);
    `CHK(cmd, 12'd0)
    cell_ma <= 12'd1000;
    bat_mv <= 13'd4000;
    wait_cmd(12'd1000);
    $display("test recharge done");
    en <= 1'b0;
    bat_mv <= 13'd2500;
    wait_cmd(12'd0);
    chk_code(4'd1);
    en <= 1'b1;
    wait_cmd(12'd100);
    apb(1'b1, 12'h000, 32'h0);
    wait_cmd(12'd0);
    apb(1'b1, 12'h000, 32'h1);
    wait_cmd(12'd100);
    bat_mv <= 13'd3600;
    wait_cmd(12'd1000);
    $display("test enable done");
    adp_mv <= 13'd3400;
    wait_cmd(12'd0);
    `CHK(adp_oe_n, 1'b0)
    adp_mv <= 13'd2000;
    chk_code(4'd0);
    `CHK(adp_oe_n, 1'b1)
    adp_mv <= 13'd5000;
    wait_cmd(12'd1000);
    $display("test supply done");
    for (i = 0; i < 3; i++) begin
      {bat_mv, die_c, ts_pct} <= {f_bat[i], f_die[i], f_ts[i]};
      wait_cmd(12'd0);
      chk_code(f_code[i]);
      {bat_mv, die_c, ts_pct} <= {13'd3600, 8'd25, 8'd45};
      wait_cmd(12'd1000);
    end
    $display("test faults done");
    en <= 1'b0;
    bat_mv <= 13'd2500;
    wait_cmd(12'd0);
    en <= 1'b1;
    wait_cmd(12'd100);
    wait_cmd(12'd0);
    chk_code(4'd11);
    en <= 1'b0;
    repeat (8) @(posedge clock);
    en <= 1'b1;
    wait_cmd(12'd100);
    $display("test safety timer done");
    end_sim();
  end
endmodule // lcs_charge_sequencer_tb
`default_nettype wire
